// *** design/tpo_timer.sv ***
// timer/counter with prescaler, overflow flag, interrupt and ahb-lite registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Contract
// - an 8-bit prescale counter sits ahead of the timer, hidden from software.
// - bypass bit clear routes the timer clock through the prescaler.
// - assigned prescaler divides from 1:2 up to 1:256 in powers of two.
// - any write to the timer count clears the prescale counter when assigned.
// - that clearing write leaves the bypass select bit untouched.
// - prescaler assignment may change at any time while the timer runs.
// - in 8-bit width, wrap from FFh to 00h sets the overflow flag.
// - in 16-bit width, wrap from FFFFh to 0000h sets the overflow flag.
// - cleared overflow enable suppresses the request but the flag still sets.
// - the timer stops during sleep, so no overflow and no wake can occur.
// - ratio field 000 divides by 2, each step doubles, 111 divides by 256.
// - bypass bit set feeds the timer clock straight to the counter.
// - after a software count write, counting waits two instruction cycles.
// - 16-bit low read copies high byte to buffer; low write loads from it.
module tpo_timer
  import tpo_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external count pin and power state
  input wire logic count_pin,
  input wire logic sleep,
  // interrupt
  output logic irq
);
  logic [7:0] timer_control_q;
  logic ovf_ie_q;
  logic overflow_flag_q;
  logic irq_status_q;
  logic irq_mask_q;
  logic [15:0] timer_count_q;
  logic [7:0] count_high_buffer_q;
  logic [1:0] holdoff_q;
  logic [1:0] inst_div_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic irq_q;

  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic wr_low;
  logic wr_high;
  logic wr_ic;
  logic wr_tc;
  logic wr_stat;
  logic wr_mask;
  logic rd_low;
  logic inst_tick;
  logic pin_edge;
  logic src_tick;
  logic run;
  logic pre_clear;
  logic pre_tick;
  logic inc;
  logic width8;
  logic ovf_event;

  // -------- bus slave
  function automatic logic mapped(input logic [7:0] a);
    return a == TPO_ADDR_COUNT_LOW || a == TPO_ADDR_COUNT_HIGH_BUF ||
           a == TPO_ADDR_INTERRUPT_CONTROL || a == TPO_ADDR_TIMER_CONTROL ||
           a == TPO_ADDR_IRQ_STATUS || a == TPO_ADDR_IRQ_MASK;
  endfunction

  assign addr_ok = hsel && hready && (htrans == TPO_HTRANS_NONSEQ || htrans == TPO_HTRANS_SEQ);
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;
  assign rd_low = rd_take && haddr == TPO_ADDR_COUNT_LOW;

  // writes land at the end of the first data cycle, which is stretched by one
  // wait state so a following read never sees a stale value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end
    else if (wr_take)
    begin
      wr_pend_q <= 1'b1;
      wr_addr_q <= haddr;
      hreadyout_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hresp_q <= 1'b0;
    else
      hresp_q <= 1'b0;
  end

  // unmapped addresses read zero and ignore writes
  assign wr_low = wr_pend_q && wr_addr_q == TPO_ADDR_COUNT_LOW && mapped(wr_addr_q);
  assign wr_high = wr_pend_q && wr_addr_q == TPO_ADDR_COUNT_HIGH_BUF;
  assign wr_ic = wr_pend_q && wr_addr_q == TPO_ADDR_INTERRUPT_CONTROL;
  assign wr_tc = wr_pend_q && wr_addr_q == TPO_ADDR_TIMER_CONTROL;
  assign wr_stat = wr_pend_q && wr_addr_q == TPO_ADDR_IRQ_STATUS;
  assign wr_mask = wr_pend_q && wr_addr_q == TPO_ADDR_IRQ_MASK;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata_q <= 32'h0000_0000;
    else if (rd_take)
    begin
      hrdata_q <= 32'h0000_0000;
      unique case (haddr)
        TPO_ADDR_COUNT_LOW: hrdata_q[7:0] <= timer_count_q[7:0];
        TPO_ADDR_COUNT_HIGH_BUF: hrdata_q[7:0] <= count_high_buffer_q;
        TPO_ADDR_INTERRUPT_CONTROL:
        begin
          hrdata_q[TPO_IC_OVF_IE] <= ovf_ie_q;
          hrdata_q[TPO_IC_OVF_FLAG] <= overflow_flag_q;
        end
        TPO_ADDR_TIMER_CONTROL: hrdata_q[7:0] <= timer_control_q;
        TPO_ADDR_IRQ_STATUS: hrdata_q[TPO_IRQ_OVF] <= irq_status_q;
        TPO_ADDR_IRQ_MASK: hrdata_q[TPO_IRQ_OVF] <= irq_mask_q;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // -------- control registers
  // prescaler assignment may change any time; the counter just follows
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_control_q <= TPO_TIMER_CONTROL_RST;
    else if (wr_tc)
      timer_control_q <= hwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ovf_ie_q <= TPO_INTERRUPT_CONTROL_RST[TPO_IC_OVF_IE];
    else if (wr_ic)
      ovf_ie_q <= hwdata[TPO_IC_OVF_IE];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_mask_q <= TPO_IRQ_MASK_RST;
    else if (wr_mask)
      irq_mask_q <= hwdata[TPO_IRQ_OVF];
  end

  assign width8 = timer_control_q[TPO_TC_WIDTH_SELECT];

  // -------- clock sources
  // instruction cycle clock: one enable pulse every four system clocks
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      inst_div_q <= 2'h0;
    else
      inst_div_q <= inst_div_q + 2'h1;
  end

  assign inst_tick = inst_div_q == TPO_INST_DIV;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= count_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // edge select set counts falling edges
  assign pin_edge = timer_control_q[TPO_TC_EDGE_SELECT] ?
                    (pin_prev_q && !pin_sync_q) : (!pin_prev_q && pin_sync_q);

  // nothing ticks while asleep or switched off
  assign run = timer_control_q[TPO_TC_ON] && !sleep;
  assign src_tick = run &&
                    (timer_control_q[TPO_TC_CLOCK_SOURCE] ? pin_edge : inst_tick);

  // -------- prescaler
  // the count write never touches timer_control, so the bypass bit stays put
  assign pre_clear = wr_low && !timer_control_q[TPO_TC_BYPASS];

  tpo_prescaler #(
    .WIDTH(8)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .clear(pre_clear),
    .src_tick(src_tick && !timer_control_q[TPO_TC_BYPASS]),
    .ratio_sel(timer_control_q[TPO_TC_RATIO_HI:0]),
    .out_tick(pre_tick)
  );

  // bypass feeds the source straight in
  assign inc = (holdoff_q == 2'h0) &&
               (timer_control_q[TPO_TC_BYPASS] ? src_tick : pre_tick);

  // -------- write hold-off
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      holdoff_q <= 2'h0;
    else if (wr_low)
      holdoff_q <= TPO_WRITE_HOLDOFF;
    else if (inst_tick && holdoff_q != 2'h0)
      holdoff_q <= holdoff_q - 2'h1;
  end

  // -------- timer count
  assign ovf_event = inc && !wr_low &&
                     (width8 ? timer_count_q[7:0] == 8'hFF :
                               timer_count_q == 16'hFFFF);

  // a software write wins over an increment in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_count_q <= 16'h0000;
    else if (wr_low)
    begin
      timer_count_q[7:0] <= hwdata[7:0];
      if (!width8)
        timer_count_q[15:8] <= count_high_buffer_q;
    end
    else if (inc)
    begin
      if (width8)
        timer_count_q[7:0] <= timer_count_q[7:0] + 8'h01;
      else
        timer_count_q <= timer_count_q + 16'h0001;
    end
  end

  // the buffer is what software writes; a low read refreshes it in 16-bit width
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_high_buffer_q <= 8'h00;
    else if (wr_high)
      count_high_buffer_q <= hwdata[7:0];
    else if (rd_low && !width8)
      count_high_buffer_q <= timer_count_q[15:8];
  end

  // -------- overflow flag and interrupt
  // the flag is never cleared by hardware; set beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      overflow_flag_q <= 1'b0;
    else if (ovf_event)
      overflow_flag_q <= 1'b1;
    else if (wr_ic)
      overflow_flag_q <= hwdata[TPO_IC_OVF_FLAG];
    else if (wr_stat && hwdata[TPO_IRQ_OVF])
      overflow_flag_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_status_q <= 1'b0;
    else if (ovf_event)
      irq_status_q <= 1'b1;
    else if (wr_stat && hwdata[TPO_IRQ_OVF])
      irq_status_q <= 1'b0;
    else if (wr_ic && !hwdata[TPO_IC_OVF_FLAG])
      irq_status_q <= 1'b0;
  end

  // enable bit gates the request, the mask register gates it again
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= overflow_flag_q && ovf_ie_q && irq_status_q && irq_mask_q;
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign irq = irq_q;

  // hsize is accepted but only whole-word transfers are expected
  logic unused_hsize;
  assign unused_hsize = ^hsize;
endmodule

// *** design/tpo_pkg.sv ***
// shared constants for the timer prescaler and overflow interrupt block
package tpo_pkg;
  // register byte addresses
  localparam logic [7:0] TPO_ADDR_COUNT_LOW = 8'h00;
  localparam logic [7:0] TPO_ADDR_COUNT_HIGH_BUF = 8'h04;
  localparam logic [7:0] TPO_ADDR_INTERRUPT_CONTROL = 8'h08;
  localparam logic [7:0] TPO_ADDR_TIMER_CONTROL = 8'h0C;
  localparam logic [7:0] TPO_ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] TPO_ADDR_IRQ_MASK = 8'h14;
  // timer_control fields
  localparam int TPO_TC_ON = 7;
  localparam int TPO_TC_WIDTH_SELECT = 6;
  localparam int TPO_TC_CLOCK_SOURCE = 5;
  localparam int TPO_TC_EDGE_SELECT = 4;
  localparam int TPO_TC_BYPASS = 3;
  localparam int TPO_TC_RATIO_HI = 2;
  // interrupt_control fields
  localparam int TPO_IC_OVF_IE = 5;
  localparam int TPO_IC_OVF_FLAG = 2;
  // irq status and mask field
  localparam int TPO_IRQ_OVF = 0;
  // reset values
  localparam logic [7:0] TPO_TIMER_CONTROL_RST = 8'hFF;
  localparam logic [7:0] TPO_INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic TPO_IRQ_MASK_RST = 1'b1;
  // counts of cycles
  localparam logic [1:0] TPO_INST_DIV = 2'h3;
  localparam logic [1:0] TPO_WRITE_HOLDOFF = 2'h2;
  // ahb-lite encodings
  localparam logic [1:0] TPO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TPO_HTRANS_SEQ = 2'h3;
endpackage

// *** design/tpo_prescaler.sv ***
// 8-bit prescale counter with power-of-two ratio select
`timescale 1ns/10ps
module tpo_prescaler
  import tpo_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic src_tick,
  input wire logic [2:0] ratio_sel,
  // output
  output logic out_tick
);
  logic [WIDTH-1:0] pre_q;
  logic [WIDTH-1:0] mask;

  // 000 gives mask 1 (divide by 2), each step adds a bit, so 111 gives all ones (divide by 256)
  function automatic logic [WIDTH-1:0] ratio_mask(input logic [2:0] sel);
    logic [WIDTH:0] one_hot;
    one_hot = '0;
    // widen before adding so that 111 reaches bit 8 instead of wrapping to bit 0
    one_hot[{1'b0, sel} + 4'h1] = 1'b1;
    return WIDTH'(one_hot - 1'b1);
  endfunction

  assign mask = ratio_mask(ratio_sel);

  // count is internal only, never visible to software
  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
      pre_q <= '0;
    else if (src_tick)
      pre_q <= pre_q + 1'b1;
  end

  assign out_tick = src_tick && ((pre_q & mask) == mask);
endmodule

// *** test/tpo_timer_props.sv ***
// port assertions for the timer block
`timescale 1ns/10ps
module tpo_timer_props
  import tpo_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // power and interrupt
  input wire logic sleep,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic ic_wr_q;
  assign take = hsel && hready && htrans[1];
  // held through the wait cycle so the data phase is known
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ic_wr_q <= 1'b0;
    else if (hready)
      ic_wr_q <= take && hwrite && haddr == TPO_ADDR_INTERRUPT_CONTROL;
  end
  enable_gate_a: assert property (
    ic_wr_q && hready && !hwdata[TPO_IC_OVF_IE] |-> ##2 !irq)
    else $error("irq up with enable cleared");
  // a register write lands two edges after its address and shows on irq one edge later
  sleep_quiet_a: assert property (sleep && $past(sleep) && $past(sleep, 2) && !$past(hsel)
    && !$past(hsel, 2) && !$past(hsel, 3) |-> !$rose(irq))
    else $error("irq rose in sleep");
  reset_out_a: assert property ($rose(rst_n) |-> hreadyout && !irq && hrdata == 32'h0)
    else $error("outputs not at reset values");
  hidden_bits_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  write_wait_a: assert property (take && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("write wait wrong");
  read_fast_a: assert property (take && !hwrite |=> hreadyout)
    else $error("read stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("error response");
  unmapped_zero_a: assert property (take && !hwrite && haddr > 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  cover property ($rose(irq));
  cover property (take && hwrite);
  cover property (sleep ##1 sleep);
endmodule

bind tpo_timer tpo_timer_props tpo_timer_props_i (.clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sleep, .irq);

// *** test/tpo_timer_test.sv ***
// self-checking bench for the timer block
`timescale 1ns/10ps
module tpo_timer_test
  import tpo_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic count_pin = 1'b0;
  logic sleep = 1'b0;
  logic irq;
  logic [31:0] seed = 32'h0000ED45;
  logic [31:0] a;
  logic [31:0] b;
  int mismatches = 0;
  int comparisons = 0;
  int d;
  int p;
  always #12.5 clk = ~clk;
  tpo_timer tpo_timer_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_pin(count_pin),
    .sleep(sleep), .irq(irq));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] e, input string w);
    comparisons++;
    if (seen !== e)
    begin
      mismatches++;
      $display("FAIL %s exp %h seen %h", w, e, seen);
    end
  endtask
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= TPO_HTRANS_NONSEQ;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    bus(ad, 1'b1, wd, r);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bus(ad, 1'b0, 32'h0, r);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input string w);
    logic [31:0] r;
    rd(ad, r);
    chk(r, e, w);
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 32'h0, "count_rst");
    rdc(8'h04, 32'h0, "buf_rst");
    rdc(8'h08, 32'h0, "ic_rst");
    rdc(8'h0C, 32'hFF, "tc_rst");
    rdc(8'h14, 32'h1, "mask_rst");
    wr(8'h18, 32'hFF);
    rdc(8'h18, 32'h0, "unmapped");
    // ratios changed while running; index 8 is bypass
    for (int r = 0; r < 9; r++)
    begin
      seed = nxt(seed);
      d = int'(seed % 3) + 1;
      p = (r == 8) ? 4 : 8 << r;
      wr(8'h0C, (r == 8) ? 32'hC8 : 32'hC0 | 32'(r));
      repeat (2 * p) @(posedge clk);
      rd(8'h00, a);
      repeat (d * p - 2) @(posedge clk);
      rd(8'h00, b);
      chk((b - a) & 32'hFF, 32'(d), "ratio");
    end
    wr(8'h0C, 32'hC7);
    repeat (500) @(posedge clk);
    wr(8'h00, 32'h10);
    repeat (990) @(posedge clk);
    rdc(8'h00, 32'h10, "clr_early");
    repeat (60) @(posedge clk);
    rdc(8'h00, 32'h11, "clr_late");
    rdc(8'h0C, 32'hC7, "tc_kept");
    wr(8'h0C, 32'hC8);
    wr(8'h00, 32'h20);
    rdc(8'h00, 32'h20, "holdoff1");
    rdc(8'h00, 32'h20, "holdoff2");
    wr(8'h08, 32'h20);
    wr(8'h00, 32'hFE);
    rdc(8'h08, 32'h20, "no_flag");
    repeat (40) @(posedge clk);
    rdc(8'h08, 32'h24, "flag8");
    chk(32'(irq), 32'h1, "irq_on");
    wr(8'h08, 32'h00);
    wr(8'h00, 32'hFE);
    repeat (40) @(posedge clk);
    rdc(8'h08, 32'h04, "flag_masked");
    chk(32'(irq), 32'h0, "irq_masked");
    rdc(8'h10, 32'h1, "status");
    wr(8'h08, 32'h24);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1, "irq_enable");
    wr(8'h14, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0, "irq_mask");
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0, "irq_clear");
    rdc(8'h08, 32'h20, "flag_clear");
    wr(8'h08, 32'h00);
    // 16-bit pairing with the timer stopped
    seed = nxt(seed);
    wr(8'h0C, 32'h08);
    wr(8'h04, {24'h0, seed[7:0]});
    wr(8'h00, {24'h0, 1'b0, seed[14:8]});
    wr(8'h04, {24'h0, seed[23:16]});
    rdc(8'h00, {24'h0, 1'b0, seed[14:8]}, "low16");
    rdc(8'h04, {24'h0, seed[7:0]}, "high16");
    for (int h = 0; h < 2; h++)
    begin
      wr(8'h0C, 32'h08);
      wr(8'h04, 32'hFE + 32'(h));
      wr(8'h00, 32'hF0);
      wr(8'h0C, 32'h88);
      repeat (100) @(posedge clk);
      rdc(8'h08, (h == 1) ? 32'h04 : 32'h0, "flag16");
    end
    wr(8'h0C, 32'hC8);
    sleep <= 1'b1;
    rd(8'h00, a);
    repeat (50) @(posedge clk);
    rd(8'h00, b);
    chk(b, a, "sleep");
    sleep <= 1'b0;
    // final rising edge is left unpaired to tell the edge modes apart
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h0C, 32'hE8 | 32'(e << 4));
      repeat (10) @(posedge clk);
      rd(8'h00, a);
      repeat (5)
      begin
        count_pin <= 1'b1;
        repeat (4) @(posedge clk);
        count_pin <= 1'b0;
        repeat (4) @(posedge clk);
      end
      count_pin <= 1'b1;
      repeat (10) @(posedge clk);
      rd(8'h00, b);
      chk((b - a) & 32'hFF, (e == 1) ? 32'h5 : 32'h6, "pin");
      count_pin <= 1'b0;
    end
    print_verdict();
  end
endmodule
